// file: logic/vpm_pkg.sv
// Package for the voice processor mode control register bank.
// Assumes one 100 MHz core clock; all widths and codes below are shared by the design files.
package vpm_pkg;

	// Register addresses on the 5-bit parallel host bus
	localparam logic [4:0] ADDR_MODE_POWER_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_ADPCM_MUTE_CONTROL = 5'h01;
	localparam logic [4:0] ADDR_PCM_SLOT_SELECT = 5'h02;
	localparam logic [4:0] ADDR_PCM_IO_CONFIG = 5'h03;
	localparam logic [4:0] ADDR_TONE_GAIN = 5'h04;
	localparam logic [4:0] ADDR_TONE_SELECT_SEND = 5'h05;

	localparam logic [7:0] REG_RESET = 8'h00;

	// Writable bit masks; unused and reserved bits read back as zero
	localparam logic [7:0] MASK_MODE_POWER = 8'h6F;
	localparam logic [7:0] MASK_ADPCM_MUTE = 8'hFF;
	localparam logic [7:0] MASK_PCM_SLOT = 8'h1F;
	localparam logic [7:0] MASK_PCM_IO = 8'h60;
	localparam logic [7:0] MASK_TONE_GAIN = 8'hFF;
	localparam logic [7:0] MASK_TONE_SEL = 8'hFF;

	// mode_power_control fields
	localparam int BIT_POWER_DOWN_HOLD = 6;
	localparam int BIT_POWER_DOWN_RESET = 5;
	localparam int MODE_MSB = 3;
	localparam int MODE_HOST_BIT = 2;
	localparam int MODE_ECHO_BIT = 0;
	localparam logic [7:0] MASK_POWER_DOWN_RESET = 8'h20;
	localparam logic [3:0] MODE_INITIAL = 4'h0;
	localparam logic [3:0] MODE_HANDSFREE = 4'h4;
	localparam logic [3:0] MODE_LINE_EXPANSION = 4'h5;

	// adpcm_mute_control fields
	localparam int BIT_ADPCM_THROUGH = 7;
	localparam int BIT_CODEC_STATE_RESET = 6;
	localparam int BIT_WHOLE_PATH_THROUGH = 5;
	localparam int BIT_TX_MUTE = 4;
	localparam int BIT_RX_MUTE = 3;
	localparam int RX_MUTE_LEVEL_MSB = 2;
	localparam logic [2:0] RX_MUTE_LEVEL_FULL = 3'h7;
	localparam int RX_MUTE_STEP_DB = 6;

	// pcm_slot_select fields
	localparam int BIT_TRANSCODER_SLOT = 4;
	localparam int LINE_SLOT_MSB = 3;
	localparam int LINE_SLOT_LSB = 2;
	localparam int ACOUSTIC_SLOT_MSB = 1;
	localparam int ACOUSTIC_SLOT_LSB = 0;

	// pcm_io_config field
	localparam int PCM_IO_ROUTING_MSB = 6;
	localparam int PCM_IO_ROUTING_LSB = 5;

	// tone_gain: 0000 is -36 dB, +2 dB per step, 1111 is -6 dB
	localparam int TX_TONE_GAIN_MSB = 7;
	localparam int TX_TONE_GAIN_LSB = 4;
	localparam int RX_TONE_GAIN_MSB = 3;
	localparam int RX_TONE_GAIN_LSB = 0;
	localparam int TONE_GAIN_BASE_DB = -36;
	localparam int TONE_GAIN_STEP_DB = 2;
	// Reference levels that the gain codes apply to, in dBm0
	localparam int DTMF_LOW_GROUP_LEVEL_DBM0 = -2;
	localparam int DTMF_HIGH_GROUP_LEVEL_DBM0 = 0;
	// Internal tone gain trim word: host writes it through the memory path
	localparam logic [8:0] TONE_TRIM_ADDR = 9'h16D;
	localparam logic [15:0] TONE_TRIM_DEFAULT = 16'h4000;
	localparam logic [15:0] TONE_TRIM_MINUS_1DB = 16'h390A;

	// tone_select_send fields
	localparam int BIT_TONE_TYPE_SELECT = 7;
	localparam int BIT_TX_TONE_SEND = 6;
	localparam int BIT_RX_TONE_SEND = 5;
	localparam int TONE_SEL_MSB = 4;
	localparam int DTMF_PAIR_MSB = 3;

	// Delay from power-up or reset release to initial mode
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_DELAY_MS = 200;
	localparam int INIT_DELAY_CYCLES = INIT_DELAY_MS * 1000000 / CLK_PERIOD_NS;

	// Synchronised pin vector layout
	localparam int PIN_COUNT = 22;
	// Idle pin levels: strobes and power pins high, so no false strobe follows reset
	localparam logic [PIN_COUNT-1:0] PIN_IDLE = 22'h380030;

	typedef enum logic [1:0] {
		ST_DOWN,
		ST_WAIT,
		ST_INIT,
		ST_RUN
	} vpm_state_e;

endpackage

// file: logic/vpm_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins.
// Assumes each bit is an independent level; multi-bit values must be held stable by the source.
`timescale 1ns/1ps
module vpm_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic core_clk, // Core clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [WIDTH-1:0] pinAsync, // Asynchronous pin levels
	output logic [WIDTH-1:0] pinSync // Synchronised levels
);

	logic [WIDTH-1:0] stageOne;

	if (WIDTH < 1) begin : gWidthCheck
		$error("vpm_sync needs WIDTH of at least 1");
	end

	// The first stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stageOne <= RESET_VALUE;
			pinSync <= RESET_VALUE;
		end else begin
			stageOne <= pinAsync;
			pinSync <= stageOne;
		end
	end

endmodule

// file: logic/vpm_mode_regs.sv
// Mode and power control register bank of the voice processor, with its parallel host port.
// Assumes host pins are asynchronous and held for several core clocks per access.
//
// Functional notes
// - External reset clears all; self reset clears rest
// - Hold bit powers down, registers kept
// - Reset bit powers down and clears registers
// - Mode codes: initial, handsfree, line expansion
// - Initial mode: idle PCM, processing off
// - Initial or valid set mode reached 200 ms after release
// - Pins ORed into mode bits 2 and 0
// - Handsfree enables all; expansion drops acoustic canceler
// - Codec through bit acts with pin low
// - Writing reset bit resets codec state
// - Whole-path through disables all processing
// - Transmit mute bit mutes transmit ADPCM
// - Receive mute applies level; pin low only
// - Level codes: none, 6 dB steps, full
// - Transcoder slot bit picks slot 1 or 2
// - Canceler slot fields pick slots 1 to 4
// - PCM outputs high impedance until the power-up delay ends
// - Tone gain nibbles, -36 dB plus 2 dB steps
// - Gain relative to DTMF reference levels
// - Tone trim word lives in internal memory
// - Tone type bit picks dialing or other tones
// - Send bits inject tone into each path
// - Low four select bits pick dialing pair
`timescale 1ns/1ps
module vpm_mode_regs
	import vpm_pkg::*;
#(
	parameter int INIT_DELAY = vpm_pkg::INIT_DELAY_CYCLES
) (
	input wire logic core_clk, // Core clock, 100 MHz
	input wire logic rst, // Synchronous reset, active high
	input wire logic busCsN, // Host chip select, active low
	input wire logic busWrN, // Host write strobe, active low
	input wire logic busRdN, // Host read strobe, active low
	input wire logic [4:0] busAddr, // Host register address
	input wire logic [7:0] busDataIn, // Host write data
	output logic [7:0] busDataOut, // Host read data
	output logic busDataOe, // High while the data pins are driven
	input wire logic powerDownHoldN, // Power-down pin, active low
	input wire logic powerDownResetN, // Power-down reset pin, active low
	input wire logic hostModeSelectPin, // ORed into mode bit 2
	input wire logic echoModePin, // ORed into mode bit 0
	input wire logic adpcmThroughPin, // External codec through control
	input wire logic muteControlPin, // External receive mute control
	output logic powerDown, // Device powered down
	output logic initialMode, // Device in initial mode
	output logic handsfreeMode, // Handsfree conversation mode active
	output logic lineExpansionMode, // Line canceler expansion mode active
	output logic toneDetectorEn, // Tone detector enable
	output logic adpcmEn, // ADPCM transcoder enable
	output logic toneGenEn, // Tone generator enable
	output logic lineCancelerEn, // Line echo canceler enable
	output logic acousticCancelerEn, // Acoustic echo canceler enable
	output logic lineLongTail, // Line canceler covers the long echo tail
	output logic pcmOutIdle, // PCM output sends idle pattern
	output logic pcmOutHiZ, // All multiplexed PCM outputs undriven
	output logic defaultMemWriteEn, // Internal default memory may change
	output logic adpcmThrough, // Codec through mode in effect
	output logic codecStateReset, // One-cycle codec state reset
	output logic wholePathThrough, // 4-bit serial data passes straight through
	output logic txMute, // Transmit ADPCM muted
	output logic [2:0] rxAttenCode, // Receive attenuation, 6 dB per step
	output logic rxFullMute, // Receive path fully muted
	output logic transcoderSlot, // Transcoder slot, 0 is slot 1
	output logic [1:0] lineSlot, // Line canceler slot, 0 is slot 1
	output logic [1:0] acousticSlot, // Acoustic canceler slot, 0 is slot 1
	output logic [1:0] pcmIoRouting, // PCM signal routing select
	output logic [3:0] txToneGain, // Transmit tone gain code
	output logic [3:0] rxToneGain, // Receive tone gain code
	output logic toneTypeSelect, // 1 selects dialing tones
	output logic txToneSend, // Inject tone into transmit path
	output logic rxToneSend, // Inject tone into receive path
	output logic [4:0] toneSelect, // Tone select field
	output logic dtmfSelected, // Dialing pair selected
	output logic [3:0] dtmfPair // Dialing pair index
);
	import vpm_pkg::*;

	localparam int WAIT_W = $clog2(INIT_DELAY + 1);

	if (INIT_DELAY < 1) begin : gDelayCheck
		$error("INIT_DELAY must be at least one cycle");
	end

	logic [PIN_COUNT-1:0] pinSync;
	logic csS, wrS, rdS, pdHoldNS, pdResetNS, hostModeS, echoModeS, thruPinS, mutePinS;
	logic [4:0] addrS;
	logic [7:0] dataS;
	logic wrActive, wrPrev, writeStrobe;
	logic [4:0] wrAddr;
	logic [7:0] wrData;
	logic [7:0] modePowerControl, adpcmMuteControl, pcmSlotSelect;
	logic [7:0] pcmIoConfig, toneGain, toneSelectSend;
	logic [7:0] next_modePowerControl;
	logic extReset, selfReset, powerDownNow;
	logic [3:0] effMode;
	logic modeValid;
	vpm_state_e state;
	logic [WAIT_W-1:0] waitCount;

	vpm_sync #(
		.WIDTH(PIN_COUNT),
		.RESET_VALUE(PIN_IDLE)
	) uPinSync (
		.core_clk(core_clk),
		.rst(rst),
		.pinAsync({busCsN, busWrN, busRdN, busAddr, busDataIn, powerDownHoldN,
			powerDownResetN, hostModeSelectPin, echoModePin, adpcmThroughPin, muteControlPin}),
		.pinSync(pinSync)
	);

	assign {csS, wrS, rdS, addrS, dataS, pdHoldNS, pdResetNS, hostModeS, echoModeS, thruPinS,
		mutePinS} = pinSync;

	// Write commits at the end of the strobe, so data set up late in the access still lands
	assign wrActive = ~csS & ~wrS;
	assign writeStrobe = wrPrev & ~wrActive;
	assign extReset = ~pdResetNS;
	assign selfReset = modePowerControl[BIT_POWER_DOWN_RESET];
	assign powerDownNow = modePowerControl[BIT_POWER_DOWN_HOLD] | ~pdHoldNS | extReset
		| selfReset;
	assign effMode = {modePowerControl[MODE_MSB],
		modePowerControl[MODE_HOST_BIT] | hostModeS,
		modePowerControl[1],
		modePowerControl[MODE_ECHO_BIT] | echoModeS};
	assign modeValid = (effMode == MODE_HANDSFREE) || (effMode == MODE_LINE_EXPANSION);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wrPrev <= 1'b0;
			wrAddr <= 5'h00;
			wrData <= 8'h00;
		end else begin
			wrPrev <= wrActive;
			if (wrActive) begin
				wrAddr <= addrS;
				wrData <= dataS;
			end
		end
	end

	// While self reset stays set all other bits are held at zero; a write that clears it loads the other bits too
	always_comb begin
		next_modePowerControl = modePowerControl;
		if (writeStrobe && wrAddr == ADDR_MODE_POWER_CONTROL) begin
			next_modePowerControl = wrData & MASK_MODE_POWER;
		end
		if (next_modePowerControl[BIT_POWER_DOWN_RESET]) begin
			next_modePowerControl = next_modePowerControl & MASK_POWER_DOWN_RESET;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst || extReset) begin
			modePowerControl <= REG_RESET;
		end else begin
			modePowerControl <= next_modePowerControl;
		end
	end

	// Power-down hold leaves these untouched; either reset clears them
	always_ff @(posedge core_clk) begin
		if (rst || extReset || selfReset) begin
			adpcmMuteControl <= REG_RESET;
			pcmSlotSelect <= REG_RESET;
			pcmIoConfig <= REG_RESET;
			toneGain <= REG_RESET;
			toneSelectSend <= REG_RESET;
		end else if (writeStrobe) begin
			case (wrAddr)
				ADDR_ADPCM_MUTE_CONTROL: adpcmMuteControl <= wrData & MASK_ADPCM_MUTE;
				ADDR_PCM_SLOT_SELECT: pcmSlotSelect <= wrData & MASK_PCM_SLOT;
				ADDR_PCM_IO_CONFIG: pcmIoConfig <= wrData & MASK_PCM_IO;
				ADDR_TONE_GAIN: toneGain <= wrData & MASK_TONE_GAIN;
				ADDR_TONE_SELECT_SEND: toneSelectSend <= wrData & MASK_TONE_SEL;
				default: ;
			endcase
		end
	end

	// Read data is registered; unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busDataOut <= 8'h00;
			busDataOe <= 1'b0;
		end else begin
			busDataOe <= ~csS & ~rdS;
			case (addrS)
				ADDR_MODE_POWER_CONTROL: busDataOut <= modePowerControl;
				ADDR_ADPCM_MUTE_CONTROL: busDataOut <= adpcmMuteControl;
				ADDR_PCM_SLOT_SELECT: busDataOut <= pcmSlotSelect;
				ADDR_PCM_IO_CONFIG: busDataOut <= pcmIoConfig;
				ADDR_TONE_GAIN: busDataOut <= toneGain;
				ADDR_TONE_SELECT_SEND: busDataOut <= toneSelectSend;
				default: busDataOut <= 8'h00;
			endcase
		end
	end

	// Power state sequencer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= ST_DOWN;
			waitCount <= '0;
		end else if (powerDownNow) begin
			state <= ST_DOWN;
			waitCount <= '0;
		end else begin
			case (state)
				ST_DOWN: begin
					state <= ST_WAIT;
					waitCount <= WAIT_W'(INIT_DELAY - 1);
				end
				ST_WAIT: begin
					if (waitCount == '0) begin
						// A valid mode, from the register or the pins, skips initial mode
						state <= modeValid ? ST_RUN : ST_INIT;
					end else begin
						waitCount <= waitCount - 1'b1;
					end
				end
				ST_INIT: begin
					if (modeValid) begin
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (!modeValid) begin
						state <= ST_INIT;
					end
				end
				default: state <= ST_DOWN;
			endcase
		end
	end

	// Functional unit enables, all registered
	always_ff @(posedge core_clk) begin
		if (rst) begin
			powerDown <= 1'b1;
			initialMode <= 1'b0;
			handsfreeMode <= 1'b0;
			lineExpansionMode <= 1'b0;
			toneDetectorEn <= 1'b0;
			adpcmEn <= 1'b0;
			toneGenEn <= 1'b0;
			lineCancelerEn <= 1'b0;
			acousticCancelerEn <= 1'b0;
			lineLongTail <= 1'b0;
			pcmOutIdle <= 1'b0;
			pcmOutHiZ <= 1'b1;
			defaultMemWriteEn <= 1'b0;
		end else begin
			powerDown <= powerDownNow;
			initialMode <= state == ST_INIT;
			handsfreeMode <= state == ST_RUN && effMode == MODE_HANDSFREE;
			lineExpansionMode <= state == ST_RUN && effMode == MODE_LINE_EXPANSION;
			toneDetectorEn <= state == ST_RUN && !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			adpcmEn <= state == ST_RUN && !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			toneGenEn <= state == ST_RUN && !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			lineCancelerEn <= state == ST_RUN && !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			acousticCancelerEn <= state == ST_RUN && effMode == MODE_HANDSFREE
				&& !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			lineLongTail <= state == ST_RUN && effMode == MODE_LINE_EXPANSION;
			pcmOutIdle <= state == ST_INIT;
			pcmOutHiZ <= state == ST_DOWN || state == ST_WAIT;
			defaultMemWriteEn <= state == ST_INIT;
		end
	end

	// Data path controls
	always_ff @(posedge core_clk) begin
		if (rst) begin
			adpcmThrough <= 1'b0;
			codecStateReset <= 1'b0;
			wholePathThrough <= 1'b0;
			txMute <= 1'b0;
			rxAttenCode <= 3'h0;
			rxFullMute <= 1'b0;
		end else begin
			// A high through pin forces through; the bit only counts while it is low
			adpcmThrough <= thruPinS | adpcmMuteControl[BIT_ADPCM_THROUGH];
			codecStateReset <= writeStrobe && wrAddr == ADDR_ADPCM_MUTE_CONTROL
				&& wrData[BIT_CODEC_STATE_RESET] && !selfReset && !extReset;
			wholePathThrough <= adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			txMute <= adpcmMuteControl[BIT_TX_MUTE]
				&& !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH];
			if ((mutePinS || adpcmMuteControl[BIT_RX_MUTE])
				&& !adpcmMuteControl[BIT_WHOLE_PATH_THROUGH]) begin
				rxAttenCode <= adpcmMuteControl[RX_MUTE_LEVEL_MSB:0];
				rxFullMute <= adpcmMuteControl[RX_MUTE_LEVEL_MSB:0]
					== RX_MUTE_LEVEL_FULL;
			end else begin
				rxAttenCode <= 3'h0;
				rxFullMute <= 1'b0;
			end
		end
	end

	// Slot, routing and tone controls
	always_ff @(posedge core_clk) begin
		if (rst) begin
			transcoderSlot <= 1'b0;
			lineSlot <= 2'h0;
			acousticSlot <= 2'h0;
			pcmIoRouting <= 2'h0;
			txToneGain <= 4'h0;
			rxToneGain <= 4'h0;
			toneTypeSelect <= 1'b0;
			txToneSend <= 1'b0;
			rxToneSend <= 1'b0;
			toneSelect <= 5'h00;
			dtmfSelected <= 1'b0;
			dtmfPair <= 4'h0;
		end else begin
			transcoderSlot <= pcmSlotSelect[BIT_TRANSCODER_SLOT];
			lineSlot <= pcmSlotSelect[LINE_SLOT_MSB:LINE_SLOT_LSB];
			acousticSlot <= pcmSlotSelect[ACOUSTIC_SLOT_MSB:ACOUSTIC_SLOT_LSB];
			pcmIoRouting <= pcmIoConfig[PCM_IO_ROUTING_MSB:PCM_IO_ROUTING_LSB];
			txToneGain <= toneGain[TX_TONE_GAIN_MSB:TX_TONE_GAIN_LSB];
			rxToneGain <= toneGain[RX_TONE_GAIN_MSB:RX_TONE_GAIN_LSB];
			toneTypeSelect <= toneSelectSend[BIT_TONE_TYPE_SELECT];
			txToneSend <= toneSelectSend[BIT_TX_TONE_SEND];
			rxToneSend <= toneSelectSend[BIT_RX_TONE_SEND];
			toneSelect <= toneSelectSend[TONE_SEL_MSB:0];
			dtmfSelected <= toneSelectSend[BIT_TONE_TYPE_SELECT];
			dtmfPair <= toneSelectSend[DTMF_PAIR_MSB:0];
		end
	end

	sequence sWriteCodecReset;
		writeStrobe && wrAddr == ADDR_ADPCM_MUTE_CONTROL && wrData[BIT_CODEC_STATE_RESET]
			&& !selfReset && !extReset;
	endsequence

	sequence sWaitDone;
		state == ST_WAIT && waitCount == '0 && !powerDownNow;
	endsequence

	AST_EXT_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
		extReset |=> modePowerControl == REG_RESET && adpcmMuteControl == REG_RESET
			&& toneGain == REG_RESET)
		else $error("external reset did not clear registers");

	AST_SELF_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
		selfReset |-> (modePowerControl & ~MASK_POWER_DOWN_RESET) == 8'h00
			##1 pcmSlotSelect == REG_RESET && toneSelectSend == REG_RESET)
		else $error("self reset left register bits set");

	AST_HOLD_POWERS_DOWN: assert property (@(posedge core_clk) disable iff (rst)
		modePowerControl[BIT_POWER_DOWN_HOLD] && !writeStrobe && !extReset
			|=> powerDown && $stable(toneGain) && $stable(pcmSlotSelect))
		else $error("power-down hold lost state or did not power down");

	AST_WAIT_LOAD: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_DOWN && !powerDownNow |=> state == ST_WAIT
			&& waitCount == WAIT_W'(INIT_DELAY - 1))
		else $error("initial mode delay not loaded");

	AST_WAIT_END: assert property (@(posedge core_clk) disable iff (rst)
		sWaitDone |=> state == ($past(modeValid) ? ST_RUN : ST_INIT) || powerDownNow)
		else $error("wait did not end in the right state");

	AST_HF_ENABLES: assert property (@(posedge core_clk) disable iff (rst)
		handsfreeMode && !wholePathThrough |-> lineCancelerEn && acousticCancelerEn
			&& adpcmEn && toneGenEn && toneDetectorEn)
		else $error("handsfree mode missing an enable");

	AST_EXPANSION_NO_ACOUSTIC: assert property (@(posedge core_clk) disable iff (rst)
		lineExpansionMode |-> !acousticCancelerEn && lineLongTail)
		else $error("expansion mode enables acoustic canceler");

	AST_THROUGH_DISABLES: assert property (@(posedge core_clk) disable iff (rst)
		adpcmMuteControl[BIT_WHOLE_PATH_THROUGH] |=> !adpcmEn && !lineCancelerEn
			&& !acousticCancelerEn && !txMute && rxAttenCode == 3'h0)
		else $error("whole-path through left processing active");

	AST_CODEC_RESET_PULSE: assert property (@(posedge core_clk) disable iff (rst)
		sWriteCodecReset |=> codecStateReset ##1 !codecStateReset || $past(writeStrobe))
		else $error("codec state reset pulse wrong");

	AST_HIZ_UNTIL_INIT: assert property (@(posedge core_clk) disable iff (rst)
		state == ST_WAIT |=> pcmOutHiZ && !pcmOutIdle)
		else $error("PCM outputs driven before initial mode");

endmodule

// file: verification/vpm_host_model.sv
// Host microcontroller model for the parallel register bus.
// Assumes one caller at a time; pins change at falling edges only.
`timescale 1ns/1ps
module vpm_host_model (
	input wire logic core_clk, // Core clock
	output logic busCsN, // Chip select, active low
	output logic busWrN, // Write strobe, active low
	output logic busRdN, // Read strobe, active low
	output logic [4:0] busAddr, // Register address
	output logic [7:0] busDataIn, // Write data
	input wire logic [7:0] busDataOut, // Read data
	input wire logic busDataOe // Device drives data
);
	initial begin
		busCsN = 1'b1;
		busWrN = 1'b1;
		busRdN = 1'b1;
		busAddr = 5'h00;
		busDataIn = 8'h00;
	end
	// Four cycles low: the device needs three synchronised samples
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge core_clk);
		busAddr = a;
		busDataIn = d;
		busCsN = 1'b0;
		busWrN = 1'b0;
		repeat (4) @(negedge core_clk);
		busCsN = 1'b1;
		busWrN = 1'b1;
		// Released lines must not look like held data
		busDataIn = ~d;
		repeat (6) @(negedge core_clk);
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge core_clk);
		busAddr = a;
		busCsN = 1'b0;
		busRdN = 1'b0;
		repeat (4) @(negedge core_clk);
		d = (busDataOe === 1'b1) ? busDataOut : 8'hXX;
		busCsN = 1'b1;
		busRdN = 1'b1;
		repeat (4) @(negedge core_clk);
	endtask
endmodule

// file: verification/voice_processor_mode_control_regs_tb.sv
// Self-checking bench for the mode control register bank.
// Assumes a shortened power-up delay; the host model drives the bus.
`timescale 1ns/1ps
`define CHECK(n, e, a) begin comparisons++; if ((a) !== (e)) begin numErrors++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
module voice_processor_mode_control_regs_tb;
	import vpm_pkg::*;
	localparam int INIT_DELAY = 8;
	logic core_clk = 1'b0, rst = 1'b1, powerDownHoldN = 1'b1, powerDownResetN = 1'b1;
	logic hostModeSelectPin = 1'b0, echoModePin = 1'b0, adpcmThroughPin = 1'b0;
	logic muteControlPin = 1'b0, busCsN, busWrN, busRdN, busDataOe, powerDown, initialMode;
	logic handsfreeMode, lineExpansionMode, adpcmEn, lineCancelerEn, acousticCancelerEn;
	logic lineLongTail, pcmOutIdle, pcmOutHiZ, defaultMemWriteEn, adpcmThrough, codecStateReset;
	logic wholePathThrough, txMute, rxFullMute, transcoderSlot, toneTypeSelect, txToneSend;
	logic rxToneSend, toneDetectorEn, toneGenEn, dtmfSelected;
	logic [1:0] lineSlot, acousticSlot, pcmIoRouting;
	logic [2:0] rxAttenCode;
	logic [3:0] txToneGain, rxToneGain, dtmfPair;
	logic [4:0] busAddr, toneSelect;
	logic [7:0] busDataIn, busDataOut, rdVal;
	int numErrors = 0, comparisons = 0, pulses = 0;
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (codecStateReset === 1'b1) pulses++;
	vpm_host_model vpm_host_model_i (.core_clk(core_clk), .busCsN(busCsN), .busWrN(busWrN),
		.busRdN(busRdN), .busAddr(busAddr), .busDataIn(busDataIn), .busDataOut(busDataOut),
		.busDataOe(busDataOe));
	vpm_mode_regs #(.INIT_DELAY(INIT_DELAY)) vpm_mode_regs_i (.core_clk(core_clk), .rst(rst),
		.busCsN(busCsN), .busWrN(busWrN), .busRdN(busRdN), .busAddr(busAddr),
		.busDataIn(busDataIn), .busDataOut(busDataOut), .busDataOe(busDataOe),
		.powerDownHoldN(powerDownHoldN), .powerDownResetN(powerDownResetN),
		.hostModeSelectPin(hostModeSelectPin), .echoModePin(echoModePin),
		.adpcmThroughPin(adpcmThroughPin), .muteControlPin(muteControlPin),
		.powerDown(powerDown), .initialMode(initialMode), .handsfreeMode(handsfreeMode),
		.lineExpansionMode(lineExpansionMode), .toneDetectorEn(toneDetectorEn),
		.adpcmEn(adpcmEn), .toneGenEn(toneGenEn), .lineCancelerEn(lineCancelerEn),
		.acousticCancelerEn(acousticCancelerEn),
		.lineLongTail(lineLongTail), .pcmOutIdle(pcmOutIdle), .pcmOutHiZ(pcmOutHiZ),
		.defaultMemWriteEn(defaultMemWriteEn), .adpcmThrough(adpcmThrough),
		.codecStateReset(codecStateReset), .wholePathThrough(wholePathThrough),
		.txMute(txMute), .rxAttenCode(rxAttenCode), .rxFullMute(rxFullMute),
		.transcoderSlot(transcoderSlot), .lineSlot(lineSlot), .acousticSlot(acousticSlot),
		.pcmIoRouting(pcmIoRouting), .txToneGain(txToneGain), .rxToneGain(rxToneGain),
		.toneTypeSelect(toneTypeSelect), .txToneSend(txToneSend), .rxToneSend(rxToneSend),
		.toneSelect(toneSelect), .dtmfSelected(dtmfSelected), .dtmfPair(dtmfPair));
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		vpm_host_model_i.wr(a, d);
	endtask
	task automatic rdChk(input logic [4:0] a, input logic [7:0] e);
		vpm_host_model_i.rd(a, rdVal);
		`CHECK("readback", e, rdVal)
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic tReset();
		// Two edges: the synchronous reset loads both synchroniser stages with PIN_IDLE each edge
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		settle(4);
		`CHECK("pcmOutHiZ", 1'b1, pcmOutHiZ)
		settle(INIT_DELAY + 8);
		`CHECK("initialMode", 1'b1, initialMode)
		`CHECK("idle", 2'h3, {pcmOutIdle, defaultMemWriteEn})
		`CHECK("pcmOutHiZ", 1'b0, pcmOutHiZ)
		for (int a = 0; a < 7; a++) rdChk(5'(a), REG_RESET);
	endtask
	task automatic tMasks();
		logic [7:0] wv[7] = '{8'h9F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
		logic [7:0] ev[7] = '{8'h0F, 8'hFF, 8'h1F, 8'h60, 8'hFF, 8'hFF, 8'h00};
		for (int a = 0; a < 7; a++) wr(5'(a), wv[a]);
		for (int a = 0; a < 7; a++) rdChk(5'(a), ev[a]);
		`CHECK("initialMode", 1'b1, initialMode)
		`CHECK("through", 5'h10, {wholePathThrough, rxAttenCode, txMute})
		`CHECK("adpcmThrough", 1'b1, adpcmThrough)
		`CHECK("pcmIoRouting", 2'h3, pcmIoRouting)
		`CHECK("pulses", 1, pulses)
	endtask
	task automatic tFields();
		wr(ADDR_ADPCM_MUTE_CONTROL, 8'h1D);
		`CHECK("mute", 5'h1A, {txMute, rxAttenCode, adpcmThrough})
		wr(ADDR_ADPCM_MUTE_CONTROL, 8'h57);
		`CHECK("rxAttenCode", 3'h0, rxAttenCode)
		muteControlPin = 1'b1;
		adpcmThroughPin = 1'b1;
		settle(5);
		`CHECK("pinMute", 5'h1F, {rxFullMute, rxAttenCode, adpcmThrough})
		`CHECK("pulses", 2, pulses)
		muteControlPin = 1'b0;
		adpcmThroughPin = 1'b0;
		wr(ADDR_PCM_SLOT_SELECT, 8'h1B);
		wr(ADDR_TONE_GAIN, 8'hA5);
		wr(ADDR_TONE_SELECT_SEND, 8'h63);
		`CHECK("slots", 5'h1B, {transcoderSlot, lineSlot, acousticSlot})
		`CHECK("toneGain", 8'hA5, {txToneGain, rxToneGain})
		`CHECK("tone", 8'h63, {toneTypeSelect, txToneSend, rxToneSend, toneSelect})
		`CHECK("dtmfPair", 5'h03, {dtmfSelected, dtmfPair})
		wr(ADDR_TONE_SELECT_SEND, 8'h8E);
		`CHECK("dtmf", 6'h3E, {toneTypeSelect, dtmfSelected, dtmfPair})
		wr(ADDR_ADPCM_MUTE_CONTROL, 8'h00);
	endtask
	task automatic tModes();
		wr(ADDR_MODE_POWER_CONTROL, {4'h0, MODE_HANDSFREE});
		`CHECK("hf", 4'hF, {handsfreeMode, acousticCancelerEn, lineCancelerEn, adpcmEn})
		`CHECK("hfUnits", 2'h3, {toneDetectorEn, toneGenEn})
		wr(ADDR_ADPCM_MUTE_CONTROL, 8'h20);
		`CHECK("adpcmEn", 1'b0, adpcmEn)
		`CHECK("thruUnits", 2'h0, {toneDetectorEn, toneGenEn})
		wr(ADDR_ADPCM_MUTE_CONTROL, 8'h00);
		wr(ADDR_MODE_POWER_CONTROL, {4'h0, MODE_LINE_EXPANSION});
		`CHECK("exp", 3'h5, {lineExpansionMode, acousticCancelerEn, lineLongTail})
		wr(ADDR_MODE_POWER_CONTROL, {4'h0, MODE_HANDSFREE});
		echoModePin = 1'b1;
		settle(6);
		`CHECK("echoPin", 1'b1, lineExpansionMode)
		echoModePin = 1'b0;
		wr(ADDR_MODE_POWER_CONTROL, REG_RESET);
		`CHECK("initialMode", 1'b1, initialMode)
		hostModeSelectPin = 1'b1;
		settle(6);
		`CHECK("hostPin", 1'b1, handsfreeMode)
		hostModeSelectPin = 1'b0;
	endtask
	task automatic tPower();
		wr(ADDR_MODE_POWER_CONTROL, 8'h44);
		`CHECK("powerDown", 1'b1, powerDown)
		rdChk(ADDR_TONE_GAIN, 8'hA5);
		wr(ADDR_MODE_POWER_CONTROL, 8'h64);
		rdChk(ADDR_MODE_POWER_CONTROL, MASK_POWER_DOWN_RESET);
		rdChk(ADDR_TONE_GAIN, REG_RESET);
		wr(ADDR_MODE_POWER_CONTROL, REG_RESET);
		wr(ADDR_TONE_GAIN, 8'h5A);
		rdChk(ADDR_TONE_GAIN, 8'h5A);
		powerDownResetN = 1'b0;
		settle(6);
		`CHECK("powerDown", 1'b1, powerDown)
		powerDownResetN = 1'b1;
		rdChk(ADDR_TONE_GAIN, REG_RESET);
		powerDownHoldN = 1'b0;
		settle(6);
		`CHECK("powerDown", 1'b1, powerDown)
		powerDownHoldN = 1'b1;
		settle(INIT_DELAY + 8);
		`CHECK("initialMode", 1'b1, initialMode)
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		tReset();
		tMasks();
		tFields();
		tModes();
		tPower();
		wrap_up();
	end
	initial begin
		#200000;
		numErrors++;
		wrap_up();
	end
endmodule
